/* shared/sbc_params.svh */
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH

// Address field widths of a packet, and the number of devices
`define SBC_DEV_W      2
`define SBC_BANK_W     5
`define SBC_NUM_DEV    4

// Width of every spacing counter
`define SBC_CNT_W      8

// Core clock cycles per channel clock cycle
`define SBC_CHAN_DIV   8

// Spacings, all counted in channel clock cycles
`define SBC_T_CC       4
`define SBC_T_CAC_CWD  4
`define SBC_T_RCD      7
`define SBC_T_RTR      8
`define SBC_T_RDP      4
`define SBC_T_RTP      4
`define SBC_T_OFFP     6

`endif

/* shared/sbc_pkg.sv */
`include "sbc_params.svh"

package sbc_pkg;

    // Commands carried in a row packet
    typedef enum logic [2:0] {
        row_idle_cmd,
        row_open_cmd,
        row_close_cmd,
        refresh_open_cmd,
        refresh_close_cmd
    } row_cmd_e;

    // Commands carried in a main column packet
    typedef enum logic [2:0] {
        column_idle_cmd,
        col_read_cmd,
        col_store_cmd,
        column_close_cmd,
        read_autoclose_cmd,
        store_autoclose_cmd
    } col_cmd_e;

    typedef struct packed {
        row_cmd_e                cmd;
        logic [`SBC_DEV_W-1:0]   dev;
        logic [`SBC_BANK_W-1:0]  bank;
    } row_req_s;

    // Main column packet plus an optional extended close in the extra packet
    typedef struct packed {
        col_cmd_e                cmd;
        logic [`SBC_DEV_W-1:0]   dev;
        logic [`SBC_BANK_W-1:0]  bank;
        logic                    ext_close;
        logic [`SBC_BANK_W-1:0]  ext_bank;
    } col_req_s;

endpackage

/* logic/split_bank_command_spacing.sv */
// Summary of operation
// - Column read or retire to a just-opened bank waits the open-to-column delay.
// - Column read or retire to a bank neighbouring an open one is refused.
// - Idle, other-device or distant-bank column packets need no spacing after an open.
// - After a row close, accesses into the closed neighbourhood are refused.
// - Column before row is judged by column-to-row spacing, not row-to-column.
// - Column-scheduled closes, extended close too, act as delayed row closes.
// - Read then store spaced by column period plus read minus write latency.
// - Other column pairs are spaced by one column packet period.
// - Store, store, read to one device spaces last store and read by retire interval.
// - That gap is filled by an idle column packet which forces the retire.
// - Store then read needs one period unless the store-store-read case applies.
// - Autoclose commands act as idle, store or read, plus a bank close.
// - Column then row needs no spacing for idle, other device or distant bank.
// - No open of a bank still being read or stored.
// - No open next to an accessed bank until that bank is closed.
// - Row close near a read bank waits the read-to-close delay.
// - Row close near a retired bank waits the retire_to_close_delay.
// - A store is retired before a row close of its bank; a read autoclose to its device can schedule a close before the retire.
// - Refresh open and refresh close are treated as row open and row close.
// - Neighbouring banks never open together; a close releases the neighbours.
`timescale 1ns/100ps
`include "sbc_params.svh"

module split_bank_command_spacing
    import sbc_pkg::*;
#(
    parameter int NUM_DEV   = `SBC_NUM_DEV,
    parameter int CHAN_DIV  = `SBC_CHAN_DIV,
    parameter int T_CC      = `SBC_T_CC,
    parameter int T_CAC_CWD = `SBC_T_CAC_CWD,
    parameter int T_RCD     = `SBC_T_RCD,
    parameter int T_RTR     = `SBC_T_RTR,
    parameter int T_RDP     = `SBC_T_RDP,
    parameter int T_RTP     = `SBC_T_RTP,
    parameter int T_OFFP    = `SBC_T_OFFP
) (
    input  wire logic     i_core_clk,
    input  wire logic     i_rst_n,
    input  wire logic     i_row_valid,
    input  wire row_req_s i_row_req,
    output logic          o_row_ready,
    input  wire logic     i_col_valid,
    input  wire col_req_s i_col_req,
    output logic          o_col_ready,
    output logic          o_chan_clk,
    output logic          o_row_pkt_valid,
    output row_req_s      o_row_pkt,
    output logic          o_col_pkt_valid,
    output col_req_s      o_col_pkt,
    output logic          o_row_illegal,
    output logic          o_col_illegal
);

    localparam int BW = `SBC_BANK_W;
    localparam int DW = `SBC_DEV_W;
    localparam int CW = `SBC_CNT_W;
    localparam int NB = 1 << BW;

    localparam logic [CW-1:0] DIV_LAST = CW'(CHAN_DIV - 1);
    localparam logic [CW-1:0] DIV_HALF = CW'(CHAN_DIV / 2);
    localparam logic [CW-1:0] CC_GAP   = CW'(T_CC);
    localparam logic [CW-1:0] RW_GAP   = CW'(T_CC + T_CAC_CWD);
    localparam logic [CW-1:0] RTR_GAP  = CW'(T_RTR);
    localparam logic [CW-1:0] RCD_LOAD = CW'(T_RCD - 1);
    localparam logic [CW-1:0] RDP_LOAD = CW'(T_RDP - 1);
    localparam logic [CW-1:0] RTP_LOAD = CW'(T_RTP - 1);
    localparam logic [CW-1:0] OFF_LOAD = CW'(T_OFFP - 1);
    localparam logic [CW-1:0] CNT_MAX  = {CW{1'b1}};

    function automatic logic [NB-1:0] oh(input logic [BW-1:0] b);
        return NB'(1) << b;
    endfunction

    // A bank and both its sense-amp neighbours
    function automatic logic [NB-1:0] adj(input logic [BW-1:0] b);
        logic [NB-1:0] o;
        o = oh(b);
        return o | (o << 1) | (o >> 1);
    endfunction

    // Per-device state
    logic [NB-1:0] open_map   [NUM_DEV];
    logic [CW-1:0] act_cnt    [NUM_DEV];
    logic [BW-1:0] act_bank   [NUM_DEV];
    logic [CW-1:0] rdp_cnt    [NUM_DEV];
    logic [BW-1:0] rdp_bank   [NUM_DEV];
    logic [CW-1:0] rtp_cnt    [NUM_DEV];
    logic [BW-1:0] rtp_bank   [NUM_DEV];
    logic [CW-1:0] close_cnt  [NUM_DEV];
    logic [BW-1:0] close_bank [NUM_DEV];
    logic          wbuf_valid [NUM_DEV];
    logic [BW-1:0] wbuf_bank  [NUM_DEV];
    logic          wbuf_close [NUM_DEV];

    // Channel clock divider; every packet slot is one channel tick
    logic [CW-1:0] div_cnt;
    wire           tick     = (div_cnt == DIV_LAST);
    wire  [CW-1:0] next_div = tick ? '0 : div_cnt + CW'(1);

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_cnt    <= '0;
            o_chan_clk <= 1'b0;
        end else begin
            div_cnt    <= next_div;
            o_chan_clk <= (next_div < DIV_HALF);
        end
    end

    // Row request decode
    wire [DW-1:0] rd         = i_row_req.dev;
    wire [BW-1:0] rb         = i_row_req.bank;
    wire [NB-1:0] row_adj    = adj(rb);
    wire          row_is_open  = (i_row_req.cmd == row_open_cmd) ||
                                 (i_row_req.cmd == refresh_open_cmd);
    wire          row_is_close = (i_row_req.cmd == row_close_cmd) ||
                                 (i_row_req.cmd == refresh_close_cmd);
    wire          row_conflict = |(open_map[rd] & row_adj);
    wire          row_illegal_now = row_is_open & row_conflict & (close_cnt[rd] == '0);
    wire          rdp_hit  = (rdp_cnt[rd] != '0) && |(row_adj & oh(rdp_bank[rd]));
    wire          rtp_hit  = (rtp_cnt[rd] != '0) && |(row_adj & oh(rtp_bank[rd]));
    wire          wbuf_hit = wbuf_valid[rd] && |(row_adj & oh(wbuf_bank[rd]));
    // An open waits out a pending column close; a close waits the column-to-row gaps
    wire          row_wait = row_is_open ? (row_conflict & !row_illegal_now) :
                             (row_is_close & (rdp_hit | rtp_hit | wbuf_hit));
    assign o_row_ready = tick & !row_wait;
    wire          row_fire  = i_row_valid & o_row_ready;
    wire          row_issue = row_fire & !row_illegal_now;

    // Column history for pair and triple spacing
    logic          last_read;
    logic          last_store;
    logic          prev_store;
    logic [DW-1:0] last_dev;
    logic [DW-1:0] prev_dev;
    logic [CW-1:0] col_since;
    logic [CW-1:0] store_since;
    logic          rtr_hold;

    // Column request decode; autoclose forms count as their base command
    wire [DW-1:0] cd       = i_col_req.dev;
    wire [BW-1:0] cb       = i_col_req.bank;
    wire          c_read   = (i_col_req.cmd == col_read_cmd) ||
                             (i_col_req.cmd == read_autoclose_cmd);
    wire          c_store  = (i_col_req.cmd == col_store_cmd) ||
                             (i_col_req.cmd == store_autoclose_cmd);
    wire          c_access = c_read | c_store;
    wire          c_close  = (i_col_req.cmd == column_close_cmd) ||
                             (i_col_req.cmd == read_autoclose_cmd) ||
                             (i_col_req.cmd == store_autoclose_cmd);
    wire          col_illegal_now = (c_access & !open_map[cd][cb]) |
                                    (c_close & i_col_req.ext_close);
    wire          rcd_wait = c_access & (act_cnt[cd] != '0) & (act_bank[cd] == cb);
    wire [CW-1:0] gap_req  = (last_read & c_store) ? RW_GAP : CC_GAP;
    wire          cc6      = prev_store & last_store & (prev_dev == last_dev) &
                             c_read & (cd == last_dev);
    wire          close_busy = (c_close | i_col_req.ext_close) &
                               ((close_cnt[cd] != '0) | wbuf_close[cd]);
    wire          rtr_wait = rtr_hold & c_read & (store_since < RTR_GAP);
    wire          col_wait = (col_since < gap_req) | rcd_wait | close_busy | rtr_wait;
    // A row close stuck behind an unretired store also gets an idle packet to retire it
    wire          retire_need = i_row_valid & row_is_close & wbuf_hit;
    wire          fill_idle = tick & (col_since >= CC_GAP) &
                              ((i_col_valid & cc6) | retire_need);
    assign o_col_ready = tick & !col_wait & !fill_idle & !cc6;
    wire          col_fire  = i_col_valid & o_col_ready;
    wire          col_issue = (col_fire & !col_illegal_now) | fill_idle;

    // What actually goes out on the column bus this slot
    wire col_req_s iss_pkt  = fill_idle ?
                              col_req_s'{cmd: column_idle_cmd, dev: last_dev, bank: '0,
                                ext_close: 1'b0, ext_bank: '0} : i_col_req;
    wire           iss_read  = (iss_pkt.cmd == col_read_cmd) ||
                               (iss_pkt.cmd == read_autoclose_cmd);
    wire           iss_store = (iss_pkt.cmd == col_store_cmd) ||
                               (iss_pkt.cmd == store_autoclose_cmd);

    // Column history; counters saturate so long idle stretches stay legal
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            last_read   <= 1'b0;
            last_store  <= 1'b0;
            prev_store  <= 1'b0;
            last_dev    <= '0;
            prev_dev    <= '0;
            col_since   <= CNT_MAX;
            store_since <= CNT_MAX;
            rtr_hold    <= 1'b0;
        end else if (col_issue) begin
            last_read   <= iss_read;
            last_store  <= iss_store;
            prev_store  <= last_store;
            last_dev    <= iss_pkt.dev;
            prev_dev    <= last_dev;
            col_since   <= CW'(1);
            store_since <= iss_store ? CW'(1) :
                           (store_since == CNT_MAX ? CNT_MAX : store_since + CW'(1));
            rtr_hold    <= fill_idle & cc6 & i_col_valid;
        end else if (tick) begin
            col_since   <= (col_since == CNT_MAX) ? CNT_MAX : col_since + CW'(1);
            store_since <= (store_since == CNT_MAX) ? CNT_MAX : store_since + CW'(1);
        end
    end

    // Per-device bank map, spacing timers and write buffer
    for (genvar d = 0; d < NUM_DEV; d++) begin : g_dev
        wire my_row   = row_issue & (rd == DW'(d));
        wire my_col   = col_issue & (iss_pkt.dev == DW'(d));
        wire retire   = col_issue & wbuf_valid[d] & !(iss_read & my_col);
        wire col_cls  = my_col & !fill_idle & (c_close & !c_store | i_col_req.ext_close);
        wire cls_done = tick & (close_cnt[d] == CW'(1));
        wire [BW-1:0] cls_tgt = i_col_req.ext_close ? i_col_req.ext_bank : cb;
        wire [NB-1:0] row_set = (my_row & row_is_open) ? oh(rb) : '0;
        wire [NB-1:0] row_clr = (my_row & row_is_close) ? row_adj : '0;
        wire [NB-1:0] auto_clr = cls_done ? adj(close_bank[d]) : '0;

        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                open_map[d] <= '0;
            end else begin
                open_map[d] <= (open_map[d] & ~row_clr & ~auto_clr) | row_set;
            end
        end

        // Open-to-column timer
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                act_cnt[d]  <= '0;
                act_bank[d] <= '0;
            end else if (my_row & row_is_open) begin
                act_cnt[d]  <= RCD_LOAD;
                act_bank[d] <= rb;
            end else if (tick & (act_cnt[d] != '0)) begin
                act_cnt[d]  <= act_cnt[d] - CW'(1);
            end
        end

        // Read-to-close timer
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                rdp_cnt[d]  <= '0;
                rdp_bank[d] <= '0;
            end else if (my_col & iss_read) begin
                rdp_cnt[d]  <= RDP_LOAD;
                rdp_bank[d] <= iss_pkt.bank;
            end else if (tick & (rdp_cnt[d] != '0)) begin
                rdp_cnt[d]  <= rdp_cnt[d] - CW'(1);
            end
        end

        // Retire-to-close timer follows the bank held in the write buffer
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                rtp_cnt[d]  <= '0;
                rtp_bank[d] <= '0;
            end else if (retire) begin
                rtp_cnt[d]  <= RTP_LOAD;
                rtp_bank[d] <= wbuf_bank[d];
            end else if (tick & (rtp_cnt[d] != '0)) begin
                rtp_cnt[d]  <= rtp_cnt[d] - CW'(1);
            end
        end

        // Write buffer; a new store refills it after retiring the old one
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                wbuf_valid[d] <= 1'b0;
                wbuf_bank[d]  <= '0;
                wbuf_close[d] <= 1'b0;
            end else if (my_col & iss_store) begin
                wbuf_valid[d] <= 1'b1;
                wbuf_bank[d]  <= iss_pkt.bank;
                wbuf_close[d] <= (iss_pkt.cmd == store_autoclose_cmd);
            end else if (retire) begin
                wbuf_valid[d] <= 1'b0;
                wbuf_close[d] <= 1'b0;
            end
        end

        // Column-scheduled close lands as a row close after the offset
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                close_cnt[d]  <= '0;
                close_bank[d] <= '0;
            end else if (retire & wbuf_close[d]) begin
                close_cnt[d]  <= OFF_LOAD;
                close_bank[d] <= wbuf_bank[d];
            end else if (col_cls) begin
                close_cnt[d]  <= OFF_LOAD;
                close_bank[d] <= cls_tgt;
            end else if (tick & (close_cnt[d] != '0)) begin
                close_cnt[d]  <= close_cnt[d] - CW'(1);
            end
        end
    end

    // Packet and refusal outputs, registered
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_row_pkt_valid <= 1'b0;
            o_row_pkt       <= '0;
            o_col_pkt_valid <= 1'b0;
            o_col_pkt       <= '0;
            o_row_illegal   <= 1'b0;
            o_col_illegal   <= 1'b0;
        end else begin
            o_row_pkt_valid <= row_issue;
            o_row_pkt       <= row_issue ? i_row_req : o_row_pkt;
            o_col_pkt_valid <= col_issue;
            o_col_pkt       <= col_issue ? iss_pkt : o_col_pkt;
            o_row_illegal   <= row_fire & row_illegal_now;
            o_col_illegal   <= col_fire & col_illegal_now & !fill_idle;
        end
    end

    default clocking cb_core @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_idle_fill;
        fill_idle & cc6 & i_col_valid;
    endsequence

    sequence s_idle_out;
        o_col_pkt_valid && (o_col_pkt.cmd == column_idle_cmd);
    endsequence

    a_open_to_col: assert property (
        col_issue && !fill_idle && c_access |->
            !((act_cnt[cd] != '0) && (act_bank[cd] == cb)))
        else $error("Column access inside open-to-column delay");

    a_access_open_bank: assert property (
        col_issue && !fill_idle && c_access |=> $past(open_map[cd][cb]))
        else $error("Column access to a bank that is not open");

    a_read_store_gap: assert property (
        col_issue && iss_store && last_read |-> col_since >= RW_GAP)
        else $error("Store too soon after read");

    a_column_period: assert property (
        col_issue |=> o_col_pkt_valid ##1 !o_col_pkt_valid[*3])
        else $error("Column packets closer than one slot");

    a_idle_fill_out: assert property (
        s_idle_fill |=> s_idle_out ##1 !(col_issue && iss_read && col_since < CC_GAP))
        else $error("Retire gap not filled by an idle packet");

    a_open_conflict: assert property (
        row_issue && row_is_open |-> !(|(open_map[rd] & row_adj)))
        else $error("Open issued beside an open bank");

    a_read_close: assert property (
        row_issue && row_is_close |-> !rdp_hit ##1 o_row_pkt_valid)
        else $error("Close too soon after a read");

    a_retire_first: assert property (
        row_issue && row_is_close |-> !wbuf_hit && !rtp_hit)
        else $error("Close issued before store retired");

    a_row_refuse: assert property (
        row_fire && row_illegal_now |=> o_row_illegal && !o_row_pkt_valid)
        else $error("Illegal open not refused");

endmodule

/* tb/sbc_device_model.sv */
`timescale 1ns/100ps
module sbc_device_model
    import sbc_pkg::*;
(
    input  wire logic     i_core_clk,
    input  wire logic     i_rst_n,
    input  wire logic     i_row_pkt_valid,
    input  wire row_req_s i_row_pkt,
    input  wire logic     i_col_pkt_valid,
    input  wire col_req_s i_col_pkt,
    output logic [7:0]    o_faults
);
    logic [31:0] open_map [4];
    logic [3:0]  wb_full;
    logic [4:0]  wb_bank [4];
    logic        rd;
    logic        wr;
    int          d;

    // A bank and the two banks that share its sense amps
    function automatic logic [31:0] near(input logic [4:0] b);
        logic [33:0] m;
        m = (34'h7 << b) >> 1;
        return m[31:0];
    endfunction

    // Rows before columns; a fault is counted, never fixed up
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_faults = 8'h00;
            wb_full = 4'h0;
            open_map = '{default: 32'h0};
        end else begin
            d = i_row_pkt.dev;
            // Refresh open and refresh close count as open and close
            if (i_row_pkt_valid && i_row_pkt.cmd inside {row_open_cmd, refresh_open_cmd}) begin
                if (|(open_map[d] & near(i_row_pkt.bank))) o_faults++;
                open_map[d][i_row_pkt.bank] = 1'b1;
            end
            if (i_row_pkt_valid && i_row_pkt.cmd inside {row_close_cmd, refresh_close_cmd}) begin
                if (wb_full[d] && |(near(i_row_pkt.bank) & (32'h1 << wb_bank[d])))
                    o_faults++;
                open_map[d] &= ~near(i_row_pkt.bank);
            end
            d = i_col_pkt.dev;
            rd = i_col_pkt.cmd inside {col_read_cmd, read_autoclose_cmd};
            wr = i_col_pkt.cmd inside {col_store_cmd, store_autoclose_cmd};
            if (i_col_pkt_valid) begin
                if ((rd || wr) && !open_map[d][i_col_pkt.bank]) o_faults++;
                // Only a read to the same device keeps a buffer pending
                for (int i = 0; i < 4; i++) begin
                    if (!(rd && d == i)) wb_full[i] = 1'b0;
                end
                if (wr) begin
                    wb_full[d] = 1'b1;
                    wb_bank[d] = i_col_pkt.bank;
                end
                if (i_col_pkt.cmd inside {column_close_cmd, read_autoclose_cmd,
                                          store_autoclose_cmd})
                    open_map[d] &= ~near(i_col_pkt.bank);
                if (i_col_pkt.ext_close) open_map[d] &= ~near(i_col_pkt.ext_bank);
            end
        end
    end
endmodule

/* tb/split_bank_command_spacing_tb_top.sv */
`timescale 1ns/100ps
module split_bank_command_spacing_tb_top
    import sbc_pkg::*;
;
    // Small counts keep the run short; all expectations use them
    localparam int DIV = 4;
    localparam int TCC = 2;
    localparam int TCW = 2;
    localparam int RCD = 4;
    localparam int RTR = 4;
    localparam int RDP = 3;
    localparam int RTP = 2;
    localparam int OFFP = 3;
    logic       clk, rst_n, row_v, col_v, row_rdy, col_rdy, chan;
    logic       row_pv, col_pv, row_ill, col_ill;
    row_req_s   row_rq, row_pkt;
    col_req_s   col_rq, col_pkt;
    logic [7:0] faults;
    int         cyc, n_idle, t_idle, miscompares, n_tests;

    split_bank_command_spacing #(.CHAN_DIV(DIV), .T_CC(TCC), .T_CAC_CWD(TCW), .T_RCD(RCD),
        .T_RTR(RTR), .T_RDP(RDP), .T_RTP(RTP), .T_OFFP(OFFP)) u_split_bank_command_spacing (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_row_valid(row_v), .i_row_req(row_rq),
        .o_row_ready(row_rdy), .i_col_valid(col_v), .i_col_req(col_rq), .o_col_ready(col_rdy),
        .o_chan_clk(chan), .o_row_pkt_valid(row_pv), .o_row_pkt(row_pkt),
        .o_col_pkt_valid(col_pv), .o_col_pkt(col_pkt), .o_row_illegal(row_ill),
        .o_col_illegal(col_ill));
    sbc_device_model u_sbc_device_model (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_row_pkt_valid(row_pv), .i_row_pkt(row_pkt), .i_col_pkt_valid(col_pv),
        .i_col_pkt(col_pkt), .o_faults(faults));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Cycle count and hang guard; a hang counts as a mismatch
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    // Idle column packets, inserted by the block or sent by the test, seen where settled
    always @(negedge clk) begin
        if (col_pv === 1'b1 && col_pkt.cmd === column_idle_cmd) begin
            n_idle++;
            t_idle = cyc;
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Hold the request until ready is seen at an edge, then read the answer
    task automatic send(input bit row, input row_req_s r, input col_req_s c, output int t,
        output logic bad);
        int g;
        @(posedge clk);
        if (row) begin
            row_v <= 1'b1;
            row_rq <= r;
        end else begin
            col_v <= 1'b1;
            col_rq <= c;
        end
        g = 0;
        do begin
            @(negedge clk);
            g++;
        end while ((row ? row_rdy : col_rdy) !== 1'b1 && g < 400);
        @(posedge clk);
        row_v <= 1'b0;
        col_v <= 1'b0;
        @(negedge clk);
        t = cyc;
        bad = row ? row_ill : col_ill;
        chk("answer", (row ? row_pv : col_pv) | bad, 1);
        // Every slot starts with the channel clock high
        chk("channel clock", chan, 1);
    endtask

    task automatic rw(input row_cmd_e k, input int d, input int b, output int t, output logic x);
        send(1'b1, '{k, 2'(d), 5'(b)}, '0, t, x);
    endtask

    task automatic cw(input col_cmd_e k, input int d, input int b, output int t, output logic x);
        send(1'b0, '0, '{k, 2'(d), 5'(b), 1'b0, 5'h00}, t, x);
    endtask

    task automatic s_row_col();
        int ta, tb, tc, td, te;
        logic x;
        rw(row_open_cmd, 0, 10, ta, x);
        cw(col_read_cmd, 0, 10, tb, x);
        chk("open to read", (tb - ta) / DIV, RCD);
        rw(row_open_cmd, 0, 5, tc, x);
        cw(col_read_cmd, 0, 10, td, x);
        chk("distant read", (td - tc) / DIV, 1);
        cw(col_read_cmd, 0, 5, te, x);
        chk("open to read 2", (te - tc) / DIV, RCD);
        cw(col_store_cmd, 0, 6, te, x);
        chk("neighbour store", x, 1);
    endtask

    task automatic s_col_col();
        int t0, t1, t2, t3, t4;
        logic x;
        rw(row_open_cmd, 1, 3, t0, x);
        cw(col_read_cmd, 0, 5, t0, x);
        cw(col_store_cmd, 0, 5, t1, x);
        chk("read to store", (t1 - t0) / DIV, TCC + TCW);
        cw(col_store_cmd, 0, 5, t2, x);
        chk("store to store", (t2 - t1) / DIV, TCC);
        t0 = n_idle;
        cw(col_read_cmd, 0, 5, t3, x);
        chk("store store read", (t3 - t2) / DIV, RTR);
        chk("idle fill", n_idle > t0, 1);
        cw(col_store_cmd, 0, 5, t1, x);
        cw(col_read_cmd, 1, 3, t2, x);
        chk("read other dev", (t2 - t1) / DIV, TCC);
        cw(col_read_cmd, 0, 10, t4, x);
        chk("read to read", (t4 - t2) / DIV, TCC);
    endtask

    task automatic s_col_row();
        int t1, t2;
        logic x;
        cw(col_read_cmd, 0, 5, t1, x);
        rw(row_close_cmd, 0, 6, t2, x);
        chk("read to close", (t2 - t1) / DIV, RDP);
        cw(col_read_cmd, 0, 5, t1, x);
        chk("read closed", x, 1);
        cw(col_read_cmd, 0, 10, t1, x);
        rw(refresh_open_cmd, 2, 0, t2, x);
        chk("read to open", (t2 - t1) / DIV, 1);
        rw(row_open_cmd, 0, 10, t1, x);
        chk("reopen", x, 1);
        rw(row_open_cmd, 0, 11, t1, x);
        chk("open neighbour", x, 1);
        cw(col_store_cmd, 1, 3, t1, x);
        t1 = n_idle;
        rw(row_close_cmd, 1, 3, t2, x);
        chk("retire fill", n_idle > t1, 1);
        chk("retire to close", (t2 - t_idle) / DIV, RTP);
        rw(refresh_close_cmd, 2, 0, t1, x);
        cw(col_read_cmd, 2, 0, t1, x);
        chk("read refreshed", x, 1);
    endtask

    // Every column-side close kind, extended close last
    task automatic s_close();
        col_cmd_e kc[4] = '{read_autoclose_cmd, column_close_cmd, store_autoclose_cmd,
                            col_read_cmd};
        int t, b;
        logic x;
        for (int k = 0; k < 4; k++) begin
            b = 4 + 8 * k;
            rw(row_open_cmd, 3, b, t, x);
            send(1'b0, '0, '{kc[k], 2'd3, 5'(b), k == 3, 5'(b)}, t, x);
            cw(column_idle_cmd, 0, 0, t, x);
            repeat ((OFFP + 2) * DIV) @(posedge clk);
            cw(col_read_cmd, 3, b, t, x);
            chk("read after close", x, 1);
            rw(row_open_cmd, 3, b + 1, t, x);
            chk("open released", x, 0);
        end
        // An autoclose that also carries an extended close is refused
        send(1'b0, '0, '{read_autoclose_cmd, 2'd3, 5'h1D, 1'b1, 5'h1D}, t, x);
        chk("double close", x, 1);
    endtask

    initial begin
        rst_n = 1'b0;
        row_v = 1'b0;
        col_v = 1'b0;
        row_rq = '0;
        col_rq = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        s_row_col();
        s_col_col();
        s_col_row();
        s_close();
        chk("device faults", faults, 0);
        stop_test();
    end
endmodule
